// ### common/mmu_fault_pkg.sv
// shared constants and carriers for the translation fault and trap unit
package mmu_fault_pkg;

    localparam int VA_W   = 64;
    localparam int PA_W   = 47;
    localparam int CTX_W  = 13;
    localparam int DATA_W = 64;
    localparam int ADDR_W = 8;

    // trap types
    localparam logic [7:0] TT_INSTR_EXC      = 8'h08;
    localparam logic [7:0] TT_INSTR_ERR      = 8'h0A;
    localparam logic [7:0] TT_DATA_EXC       = 8'h30;
    localparam logic [7:0] TT_DATA_ERR       = 8'h32;
    localparam logic [7:0] TT_MISALIGN_A     = 8'h35;
    localparam logic [7:0] TT_MISALIGN_B     = 8'h36;
    localparam logic [7:0] TT_PRIV_ACTION    = 8'h37;
    localparam logic [7:0] TT_MISALIGN_C     = 8'h38;
    localparam logic [7:0] TT_MISALIGN_D     = 8'h39;
    localparam logic [7:0] TT_WATCH_VA       = 8'h61;
    localparam logic [7:0] TT_WATCH_PA       = 8'h62;
    localparam logic [7:0] TT_ITLB_MISS_BASE = 8'h64;
    localparam logic [7:0] TT_DTLB_MISS_BASE = 8'h68;
    localparam logic [7:0] TT_PROT_BASE      = 8'h6C;

    // register offsets (byte addresses)
    localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_IFS  = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_ITAG = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_DFS  = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_DFA  = 8'h20;
    localparam logic [ADDR_W-1:0] OFF_DTAG = 8'h28;

    // field positions and reset values
    localparam int CTRL_XLATE_BIT = 0;
    localparam int FS_VALID_BIT   = 0;
    localparam int FS_OVF_BIT     = 1;
    localparam logic RST_XLATE_EN = 1'b0;

    typedef struct packed {
        logic invertEndian;
        logic privilegedPage;
        logic writable;
        logic nonfaultOnly;
        logic virtCacheable;
        logic physCacheable;
        logic sideEffect;
    } tte_attr_s;

    localparam tte_attr_s IMPLIED_ATTR = '{
        invertEndian: 1'b0, privilegedPage: 1'b0, writable: 1'b1, nonfaultOnly: 1'b0,
        virtCacheable: 1'b0, physCacheable: 1'b0, sideEffect: 1'b1};

    typedef struct packed {
        logic [7:0] trapType;
        logic [5:0] rsvd;
        logic       overflow;
        logic       valid;
    } fault_status_s;

    typedef struct packed {
        logic            valid;
        logic            tlbMiss;
        logic [1:0]      missSel;
        logic            accessExc;
        logic            uncorrErr;
        logic            busErr;
        logic            multiHit;
        logic            parityErr;
        logic [VA_W-1:0] va;
    } instr_access_s;

    typedef struct packed {
        logic             valid;
        logic             isLoad;
        logic             isPrefetch;
        logic             isNonfault;
        logic             fromJumpLink;
        logic             storeFwd;
        logic             misaligned;
        logic [1:0]       misSel;
        logic             privAsi;
        logic             accessExc;
        logic             tlbMiss;
        logic [1:0]       missSel;
        logic             protViol;
        logic [1:0]       protSel;
        logic             watchHit;
        logic             watchSel;
        logic             uncorrErr;
        logic             busErr;
        logic             multiHit;
        logic             parityErr;
        logic [VA_W-1:0]  va;
        logic [CTX_W-1:0] ctxId;
        logic [PA_W-1:0]  pa;
        tte_attr_s        attr;
    } data_access_s;

    typedef struct packed {
        logic       valid;
        logic [7:0] trapType;
        logic       iUpd;
        logic       iTagUpd;
        logic       dUpd;
        logic       dTagUpd;
        logic       restrain;
    } trap_sel_s;

    typedef struct packed {
        logic       valid;
        logic [7:0] trapType;
    } trap_s;

    typedef struct packed {
        logic            valid;
        logic [PA_W-1:0] pa;
        tte_attr_s       attr;
    } mem_req_s;

endpackage

// ### src/mmu_fault_trap.sv
// fault classification, trap selection and fault status capture
`timescale 1ns/1ps

// Summary of operation
// - Instruction miss, exception 08 and error 0A trap and update instruction fault status.
// - Data miss, exception, protection, watchpoint and data error update status and address.
// - A privileged address space from user code traps with 37, leaving data tag access alone.
// - After a data access exception the data tag access context field is undefined.
// - A misaligned trap from jump-and-link or return captures no data status or address.
// - An uncorrectable or bus error on an instruction fetch raises instruction access error.
// - Multiple hits or entry parity error in the instruction TLB raise access error 0A.
// - An uncorrectable or bus error on an operand access, other than a load forwarded from the store buffer, raises data access error 32.
// - Multiple hits or entry parity error in the data TLB raise data access error 32.
// - A load forwarded from the store buffer reports a restrainable error, not error 32.
// - Physical addresses sent to the system bus are 47 bits wide.
// - With data translation off, accesses carry fixed implied page attributes.
// - With data translation off, a prefetch completes without any memory access.
// - With data translation off, a nonfaulting load raises data access exception 30.
// - The control register has no cacheable enable bits for the translation units.
module mmu_fault_trap (
    input  wire logic                                 clk,
    input  wire logic                                 rst,
    input  wire logic [mmu_fault_pkg::ADDR_W-1:0]     regAddr,
    input  wire logic [mmu_fault_pkg::DATA_W-1:0]     regWrData,
    input  wire logic                                 regWr,
    input  wire logic                                 regRd,
    output logic      [mmu_fault_pkg::DATA_W-1:0]     regRdData,
    input  wire mmu_fault_pkg::instr_access_s         instrIn,
    input  wire mmu_fault_pkg::data_access_s          dataIn,
    output mmu_fault_pkg::trap_s                      trapOut,
    output logic                                      restrainErr,
    output logic                                      prefetchDone,
    output mmu_fault_pkg::mem_req_s                   memReq
);

    typedef struct packed {
        logic                                dataXlateEn;
        mmu_fault_pkg::fault_status_s        instrFaultStatus;
        logic [mmu_fault_pkg::VA_W-1:0]      instrTagAccess;
        mmu_fault_pkg::fault_status_s        dataFaultStatus;
        logic [mmu_fault_pkg::VA_W-1:0]      dataFaultAddress;
        logic [mmu_fault_pkg::VA_W-1:0]      dataTagAccess;
        mmu_fault_pkg::trap_s                trap;
        logic                                restrainErr;
        logic                                prefetchDone;
        mmu_fault_pkg::mem_req_s             memReq;
        logic [mmu_fault_pkg::DATA_W-1:0]    rdData;
    } state_s;

    state_s                   state_reg;
    state_s                   state_next;
    mmu_fault_pkg::trap_sel_s sel;

    function automatic logic [7:0] misalignType(input logic [1:0] s);
        case (s)
            2'h0:    misalignType = mmu_fault_pkg::TT_MISALIGN_A;
            2'h1:    misalignType = mmu_fault_pkg::TT_MISALIGN_B;
            2'h2:    misalignType = mmu_fault_pkg::TT_MISALIGN_C;
            default: misalignType = mmu_fault_pkg::TT_MISALIGN_D;
        endcase
    endfunction

    // fixed priority walk, instruction side first
    function automatic mmu_fault_pkg::trap_sel_s selectTrap(
        input mmu_fault_pkg::instr_access_s i,
        input mmu_fault_pkg::data_access_s  d,
        input logic                         xlate);
        mmu_fault_pkg::trap_sel_s r;
        logic                     errFwd;
        r = '0;
        errFwd = d.isLoad && d.storeFwd && (d.uncorrErr || d.busErr);
        if (i.valid && (i.uncorrErr || i.busErr || i.multiHit || i.parityErr)) begin
            r.trapType = mmu_fault_pkg::TT_INSTR_ERR;
            r.iUpd = 1'b1;
        end else if (i.valid && i.tlbMiss) begin
            r.trapType = mmu_fault_pkg::TT_ITLB_MISS_BASE + {6'h00, i.missSel};
            r.iUpd = 1'b1;
            r.iTagUpd = 1'b1;
        end else if (i.valid && i.accessExc) begin
            r.trapType = mmu_fault_pkg::TT_INSTR_EXC;
            r.iUpd = 1'b1;
            r.iTagUpd = 1'b1;
        end else if (d.valid && d.misaligned) begin
            r.trapType = misalignType(d.misSel);
            r.dUpd = !d.fromJumpLink;
        end else if (d.valid && d.privAsi) begin
            r.trapType = mmu_fault_pkg::TT_PRIV_ACTION;
            r.dUpd = 1'b1;
        end else if (d.valid && (d.accessExc || (d.isNonfault && !xlate))) begin
            r.trapType = mmu_fault_pkg::TT_DATA_EXC;
            r.dUpd = 1'b1;
            r.dTagUpd = 1'b1;
        end else if (d.valid && d.tlbMiss) begin
            r.trapType = mmu_fault_pkg::TT_DTLB_MISS_BASE + {6'h00, d.missSel};
            r.dUpd = 1'b1;
            r.dTagUpd = 1'b1;
        end else if (d.valid && d.protViol) begin
            r.trapType = mmu_fault_pkg::TT_PROT_BASE + {6'h00, d.protSel};
            r.dUpd = 1'b1;
            r.dTagUpd = 1'b1;
        end else if (d.valid && d.watchHit) begin
            r.trapType = d.watchSel ? mmu_fault_pkg::TT_WATCH_PA : mmu_fault_pkg::TT_WATCH_VA;
            r.dUpd = 1'b1;
        end else if (d.valid && (d.multiHit || d.parityErr
                                 || ((d.uncorrErr || d.busErr) && !errFwd))) begin
            r.trapType = mmu_fault_pkg::TT_DATA_ERR;
            r.dUpd = 1'b1;
        end
        r.valid = r.iUpd || r.iTagUpd || r.dUpd || r.dTagUpd
                  || (d.valid && d.misaligned && !(i.valid && (i.tlbMiss || i.accessExc
                      || i.uncorrErr || i.busErr || i.multiHit || i.parityErr)));
        r.restrain = d.valid && errFwd;
        return r;
    endfunction

    // status capture: set wins over a same-cycle software clear
    function automatic mmu_fault_pkg::fault_status_s captureStatus(
        input mmu_fault_pkg::fault_status_s cur,
        input logic [7:0]                   tt);
        mmu_fault_pkg::fault_status_s r;
        r = cur;
        r.overflow = cur.valid || cur.overflow;
        r.valid = 1'b1;
        r.trapType = tt;
        return r;
    endfunction

    assign sel = selectTrap(instrIn, dataIn, state_reg.dataXlateEn);

    always_comb begin
        state_next = state_reg;
        state_next.trap = '0;
        state_next.restrainErr = 1'b0;
        state_next.prefetchDone = 1'b0;
        state_next.memReq = '0;
        state_next.rdData = '0;
        if (regWr) begin
            case (regAddr)
                mmu_fault_pkg::OFF_CTRL: begin
                    // only the translation enable exists here
                    state_next.dataXlateEn = regWrData[mmu_fault_pkg::CTRL_XLATE_BIT];
                end
                mmu_fault_pkg::OFF_IFS: begin
                    if (regWrData[mmu_fault_pkg::FS_VALID_BIT]) begin
                        state_next.instrFaultStatus.valid = 1'b0;
                    end
                    if (regWrData[mmu_fault_pkg::FS_OVF_BIT]) begin
                        state_next.instrFaultStatus.overflow = 1'b0;
                    end
                end
                mmu_fault_pkg::OFF_DFS: begin
                    if (regWrData[mmu_fault_pkg::FS_VALID_BIT]) begin
                        state_next.dataFaultStatus.valid = 1'b0;
                    end
                    if (regWrData[mmu_fault_pkg::FS_OVF_BIT]) begin
                        state_next.dataFaultStatus.overflow = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        if (regRd) begin
            case (regAddr)
                mmu_fault_pkg::OFF_CTRL: state_next.rdData = {63'h0, state_reg.dataXlateEn};
                mmu_fault_pkg::OFF_IFS:  state_next.rdData = {48'h0, state_reg.instrFaultStatus};
                mmu_fault_pkg::OFF_ITAG: state_next.rdData = state_reg.instrTagAccess;
                mmu_fault_pkg::OFF_DFS:  state_next.rdData = {48'h0, state_reg.dataFaultStatus};
                mmu_fault_pkg::OFF_DFA:  state_next.rdData = state_reg.dataFaultAddress;
                mmu_fault_pkg::OFF_DTAG: state_next.rdData = state_reg.dataTagAccess;
                default:                 state_next.rdData = '0;
            endcase
        end
        // one trap per cycle, one side of status touched
        state_next.trap.valid = sel.valid;
        state_next.trap.trapType = sel.trapType;
        state_next.restrainErr = sel.restrain;
        if (sel.iUpd) begin
            state_next.instrFaultStatus =
                captureStatus(state_next.instrFaultStatus, sel.trapType);
        end
        if (sel.iTagUpd) begin
            state_next.instrTagAccess = instrIn.va;
        end
        if (sel.dUpd) begin
            state_next.dataFaultStatus =
                captureStatus(state_next.dataFaultStatus, sel.trapType);
            state_next.dataFaultAddress = dataIn.va;
        end
        if (sel.dTagUpd) begin
            // context field left to whatever the access carried
            state_next.dataTagAccess = {dataIn.va[mmu_fault_pkg::VA_W-1:mmu_fault_pkg::CTX_W],
                                        dataIn.ctxId};
        end
        if (dataIn.valid && !sel.valid) begin
            if (dataIn.isPrefetch && !state_reg.dataXlateEn) begin
                state_next.prefetchDone = 1'b1;
            end else begin
                state_next.memReq.valid = 1'b1;
                state_next.memReq.pa = dataIn.pa;
                state_next.memReq.attr = state_reg.dataXlateEn ? dataIn.attr
                                         : mmu_fault_pkg::IMPLIED_ATTR;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= '0;
            state_reg.dataXlateEn <= mmu_fault_pkg::RST_XLATE_EN;
        end else begin
            state_reg <= state_next;
        end
    end

    assign regRdData    = state_reg.rdData;
    assign trapOut      = state_reg.trap;
    assign restrainErr  = state_reg.restrainErr;
    assign prefetchDone = state_reg.prefetchDone;
    assign memReq       = state_reg.memReq;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    chk_instr_err_fetch: assert property (
        instrIn.valid && (instrIn.uncorrErr || instrIn.busErr)
        |=> trapOut.valid && trapOut.trapType == mmu_fault_pkg::TT_INSTR_ERR)
        else $error("fetch error did not raise instruction access error");

    chk_instr_err_tlb: assert property (
        instrIn.valid && (instrIn.multiHit || instrIn.parityErr)
        |=> trapOut.trapType == mmu_fault_pkg::TT_INSTR_ERR
            && instrFaultStatusType() == mmu_fault_pkg::TT_INSTR_ERR)
        else $error("instruction tlb error not reported");

    chk_instr_exc_status: assert property (
        trapOut.valid && trapOut.trapType == mmu_fault_pkg::TT_INSTR_EXC
        |-> state_reg.instrFaultStatus.valid
            && state_reg.instrTagAccess == $past(instrIn.va))
        else $error("instruction exception did not capture status");

    chk_dmiss_address: assert property (
        trapOut.valid && trapOut.trapType[7:2] == mmu_fault_pkg::TT_DTLB_MISS_BASE[7:2]
        |-> state_reg.dataFaultAddress == $past(dataIn.va) && state_reg.dataFaultStatus.valid)
        else $error("data miss did not capture fault address");

    chk_priv_no_tag: assert property (
        trapOut.valid && trapOut.trapType == mmu_fault_pkg::TT_PRIV_ACTION
        |-> state_reg.dataTagAccess == $past(state_reg.dataTagAccess))
        else $error("privileged action changed data tag access");

    chk_jump_no_capture: assert property (
        dataIn.valid && dataIn.misaligned && dataIn.fromJumpLink
        |=> state_reg.dataFaultAddress == $past(state_reg.dataFaultAddress))
        else $error("jump misalignment captured fault address");

    chk_data_err_bus: assert property (
        trapOut.valid && trapOut.trapType == mmu_fault_pkg::TT_DATA_ERR
        |-> $past(dataIn.multiHit || dataIn.parityErr || dataIn.uncorrErr || dataIn.busErr))
        else $error("data access error without a cause");

    chk_data_err_tlb: assert property (
        dataIn.valid && dataIn.multiHit && !instrIn.valid && !dataIn.misaligned
        && !dataIn.privAsi && !dataIn.accessExc && !dataIn.isNonfault && !dataIn.tlbMiss
        && !dataIn.protViol && !dataIn.watchHit
        |=> trapOut.trapType == mmu_fault_pkg::TT_DATA_ERR)
        else $error("data tlb multiple hit not reported");

    chk_fwd_restrain: assert property (
        dataIn.valid && dataIn.isLoad && dataIn.storeFwd && (dataIn.busErr || dataIn.uncorrErr)
        && !dataIn.multiHit && !dataIn.parityErr
        |=> restrainErr && !(trapOut.valid && trapOut.trapType == mmu_fault_pkg::TT_DATA_ERR))
        else $error("forwarded load error not restrained");

    chk_implied_attr: assert property (
        memReq.valid && !$past(state_reg.dataXlateEn)
        |-> memReq.attr == mmu_fault_pkg::IMPLIED_ATTR)
        else $error("implied attributes not applied");

    chk_prefetch_quiet: assert property (
        dataIn.valid && dataIn.isPrefetch && !state_reg.dataXlateEn
        |=> !memReq.valid)
        else $error("prefetch issued a memory access");

    chk_nonfault_exc: assert property (
        dataIn.valid && dataIn.isNonfault && !state_reg.dataXlateEn && !instrIn.valid
        && !dataIn.misaligned && !dataIn.privAsi
        |=> trapOut.valid && trapOut.trapType == mmu_fault_pkg::TT_DATA_EXC)
        else $error("nonfaulting load did not trap");

    chk_single_side: assert property (
        trapOut.valid |-> !($changed(state_reg.instrFaultStatus)
                            && $changed(state_reg.dataFaultStatus)))
        else $error("both fault status registers updated by one trap");

    cov_instr_miss: cover property (trapOut.valid
        && trapOut.trapType[7:2] == mmu_fault_pkg::TT_ITLB_MISS_BASE[7:2]);
    cov_prot_trap: cover property (trapOut.valid
        && trapOut.trapType[7:2] == mmu_fault_pkg::TT_PROT_BASE[7:2]);
    cov_xlate_off_access: cover property (memReq.valid && !state_reg.dataXlateEn);
    cov_overflow: cover property (state_reg.dataFaultStatus.overflow);

    function automatic logic [7:0] instrFaultStatusType();
        return state_reg.instrFaultStatus.trapType;
    endfunction

endmodule

// ### bench/core_model.sv
// core side model: trap dispatch counting each trap pulse
`timescale 1ns/1ps

module core_model (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire mmu_fault_pkg::trap_s trapOut,
    output logic [15:0]               trapCnt
);
    // one dispatch per pulse
    always_ff @(posedge clk) begin
        if (rst) begin
            trapCnt <= 16'h0;
        end else begin
            trapCnt <= trapCnt + 16'(trapOut.valid);
        end
    end
endmodule

// ### bench/tb.sv
// self-checking bench for the fault and trap unit
`timescale 1ns/1ps
`define CHK(n, e, s) begin samples_checked++; if ((e) !== (s)) begin errors++; \
    $display("BAD %s exp %0h got %0h", n, e, s); end end

module tb;
    logic                             clk = 1'b0;
    logic                             rst = 1'b1;
    logic [mmu_fault_pkg::ADDR_W-1:0] regAddr = 8'h00;
    logic [mmu_fault_pkg::DATA_W-1:0] regWrData = 64'h0;
    logic                             regWr = 1'b0;
    logic                             regRd = 1'b0;
    logic [mmu_fault_pkg::DATA_W-1:0] regRdData;
    mmu_fault_pkg::instr_access_s     instrIn = '0;
    mmu_fault_pkg::data_access_s      dataIn = '0;
    mmu_fault_pkg::trap_s             trapOut;
    logic                             restrainErr;
    logic                             prefetchDone;
    mmu_fault_pkg::mem_req_s          memReq;
    logic [15:0]                      trapCnt;
    int                               errors = 0;
    int                               samples_checked = 0;
    int                               expTraps = 0;
    logic [31:0]                      seed = 32'h27CE0E49;

    always #50 clk = ~clk;

    mmu_fault_trap mmu_fault_trap_i (.clk(clk), .rst(rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .instrIn(instrIn), .dataIn(dataIn), .trapOut(trapOut), .restrainErr(restrainErr),
        .prefetchDone(prefetchDone), .memReq(memReq));
    core_model core_model_i (.clk(clk), .rst(rst), .trapOut(trapOut), .trapCnt(trapCnt));

    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction

    function automatic mmu_fault_pkg::data_access_s rnd_d();
        mmu_fault_pkg::data_access_s d;
        d = '0;
        d.valid = 1'b1;
        d.isLoad = 1'b1;
        d.va = {rnd(), rnd()};
        d.ctxId = 13'(rnd());
        d.pa = 47'({rnd(), rnd()});
        d.attr = 7'(rnd());
        return d;
    endfunction

    function automatic logic [7:0] exp_tt(input int k);
        logic [7:0] mis [4] = '{8'h35, 8'h36, 8'h38, 8'h39};
        if (k < 4) return mmu_fault_pkg::TT_DTLB_MISS_BASE + 8'(k);
        if (k < 8) return mmu_fault_pkg::TT_PROT_BASE + 8'(k - 4);
        if (k < 12) return mis[k - 8];
        return mmu_fault_pkg::TT_WATCH_VA + 8'(k - 12);
    endfunction

    task automatic wr(input logic [7:0] a, input logic [63:0] v);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= v;
        @(posedge clk);
        regWr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [63:0] q);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        q = regRdData;
    endtask

    task automatic ev(input mmu_fault_pkg::instr_access_s i,
                      input mmu_fault_pkg::data_access_s d);
        @(posedge clk);
        instrIn <= i;
        dataIn <= d;
        @(posedge clk);
        instrIn <= '0;
        dataIn <= '0;
        #1;
    endtask

    task automatic stop_test();
        $display("checked %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        stop_test();
    end

    initial begin
        mmu_fault_pkg::data_access_s  d;
        mmu_fault_pkg::instr_access_s i;
        logic [63:0]                  q;
        logic [63:0]                  expDfa;
        logic [63:0]                  expDtag;
        logic [7:0]                   expDfs;
        logic [7:0]                   expIfs;
        logic [63:0]                  expItag;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rd(mmu_fault_pkg::OFF_CTRL, q);
        `CHK("ctrl reset", 64'h0, q)
        d = rnd_d();
        d.isNonfault = 1'b1;
        ev('0, d);
        expTraps++;
        `CHK("nonfault", {1'b1, mmu_fault_pkg::TT_DATA_EXC}, trapOut)
        d = rnd_d();
        d.isLoad = 1'b0;
        d.isPrefetch = 1'b1;
        ev('0, d);
        `CHK("prefetch", 2'b10, {prefetchDone, memReq.valid})
        d = rnd_d();
        ev('0, d);
        `CHK("implied attr", mmu_fault_pkg::IMPLIED_ATTR, memReq.attr)
        `CHK("bus pa", {1'b1, d.pa}, {memReq.valid, memReq.pa})
        wr(mmu_fault_pkg::OFF_CTRL, 64'hFFFFFFFFFFFFFFFF);
        rd(mmu_fault_pkg::OFF_CTRL, q);
        `CHK("ctrl bits", 64'h1, q)
        for (int k = 0; k < 14; k++) begin
            d = rnd_d();
            case (k / 4)
                0: begin
                    d.tlbMiss = 1'b1;
                    d.missSel = 2'(k);
                end
                1: begin
                    d.protViol = 1'b1;
                    d.protSel = 2'(k);
                end
                2: begin
                    d.misaligned = 1'b1;
                    d.misSel = 2'(k);
                    d.fromJumpLink = 1'b1;
                end
                default: begin
                    d.watchHit = 1'b1;
                    d.watchSel = k[0];
                end
            endcase
            ev('0, d);
            expTraps++;
            `CHK("data trap", {1'b1, exp_tt(k)}, trapOut)
            if (k < 8 || k > 11) begin
                expDfs = exp_tt(k);
                expDfa = d.va;
            end
            if (k < 8) expDtag = {d.va[63:13], d.ctxId};
            rd(mmu_fault_pkg::OFF_DFS, q);
            `CHK("dfs type", expDfs, q[15:8])
            rd(mmu_fault_pkg::OFF_DFA, q);
            `CHK("dfa", expDfa, q)
            rd(mmu_fault_pkg::OFF_DTAG, q);
            `CHK("dtag", expDtag, q)
        end
        wr(mmu_fault_pkg::OFF_DFA, 64'hFFFFFFFFFFFFFFFF);
        rd(mmu_fault_pkg::OFF_DFA, q);
        `CHK("dfa read only", expDfa, q)
        for (int j = 0; j < 5; j++) begin
            d = rnd_d();
            {d.uncorrErr, d.busErr, d.multiHit, d.parityErr} = 4'b1000 >> j;
            d.privAsi = (j == 4);
            ev('0, d);
            expTraps++;
            expDfs = (j == 4) ? mmu_fault_pkg::TT_PRIV_ACTION : mmu_fault_pkg::TT_DATA_ERR;
            `CHK("err trap", {1'b1, expDfs}, trapOut)
            rd(mmu_fault_pkg::OFF_DFS, q);
            `CHK("dfs err", expDfs, q[15:8])
            rd(mmu_fault_pkg::OFF_DTAG, q);
            `CHK("dtag kept", expDtag, q)
        end
        expItag = 64'h0;
        for (int j = 0; j < 6; j++) begin
            i = '0;
            i.valid = 1'b1;
            i.va = {rnd(), rnd()};
            i.accessExc = (j == 0);
            {i.uncorrErr, i.busErr, i.multiHit, i.parityErr} = 4'(5'h10 >> j);
            i.tlbMiss = (j == 5);
            i.missSel = 2'(j);
            ev(i, '0);
            expTraps++;
            if (j == 0 || j == 5) expItag = i.va;
            expIfs = (j == 5) ? mmu_fault_pkg::TT_ITLB_MISS_BASE + 8'h1
                   : (j == 0) ? mmu_fault_pkg::TT_INSTR_EXC : mmu_fault_pkg::TT_INSTR_ERR;
            `CHK("instr trap", {1'b1, expIfs}, trapOut)
            rd(mmu_fault_pkg::OFF_IFS, q);
            `CHK("ifs type", expIfs, q[15:8])
            rd(mmu_fault_pkg::OFF_ITAG, q);
            `CHK("itag", expItag, q)
        end
        d = rnd_d();
        d.storeFwd = 1'b1;
        d.uncorrErr = 1'b1;
        ev('0, d);
        `CHK("restrain", 2'b10, {restrainErr, trapOut.valid})
        `CHK("xlate attr", d.attr, memReq.attr)
        i = '0;
        i.valid = 1'b1;
        i.parityErr = 1'b1;
        d = rnd_d();
        d.tlbMiss = 1'b1;
        ev(i, d);
        expTraps++;
        `CHK("one trap", {1'b1, mmu_fault_pkg::TT_INSTR_ERR}, trapOut)
        rd(mmu_fault_pkg::OFF_DFS, q);
        `CHK("dfs untouched", expDfs, q[15:8])
        `CHK("dfs flags", 2'b11, q[1:0])
        wr(mmu_fault_pkg::OFF_DFS, 64'h3);
        rd(mmu_fault_pkg::OFF_DFS, q);
        `CHK("dfs clear", {expDfs, 8'h00}, q[15:0])
        `CHK("trap count", 16'(expTraps), trapCnt)
        rd(8'hF8, q);
        `CHK("unmapped", 64'h0, q)
        stop_test();
    end
endmodule
